/* File: irq_channel_pkg.sv */
// constants shared by the interrupt channel register block
package irq_channel_pkg;

    // ==========================================================
    // bus geometry, channel counts and field widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 32;
    localparam int NUM_FAST = 2;
    localparam int PRIO_W = 4;
    localparam int CHAN_W = 5;
    localparam int VEC_W = 16;

    // ==========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] VECTOR_READOUT_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] FAST_CHANNEL_CONTROL_OFS = 8'h1c;
    localparam logic [ADDR_W-1:0] CHANNEL_ENABLE_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] CHANNEL_PENDING_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] SOURCE_FIRST_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] SOURCE_LAST_OFS = 8'hdc;

    // ==========================================================
    // field positions
    localparam int FAST_ENABLE_LSB = 0;
    localparam int FAST_PENDING_LSB = 2;
    localparam int SOURCE_VECTOR_LSB = 16;
    localparam int SOURCE_PRIO_LSB = 0;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
    localparam logic [VEC_W-1:0] VECTOR_RESET = 16'h0000;

    // ==========================================================
    // priority stack and bus answers
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: irq_channel_regs.sv */
// channel enable, pending and source registers with priority stack
//
// Overview of operation
// R1 - fast channel answers only when enabled
// R2 - fast request sets its pending bit
// R3 - fast pending: write one clears, hardware never
// R4 - thirty-two read-write channel enable bits
// R5 - disabled channel never sets its pending bit
// R6 - pending set by enabled request, held
// R7 - channel pending cleared by writing one
// R8 - serviced channel clear is end-of-interrupt, pops
// R9 - irq line held until vector read/reset
// R10 - early clear of serviced bit still pops
// R11 - software clears serviced bit at routine end
// R12 - disable globally before clearing other channels
// R13 - global enable low freezes stack, pop lost
// R14 - thirty-two source registers at 60h to DCh
// R15 - source upper half supplied on vector read
// R16 - source low nibble holds priority, resets zero
// R17 - serve only above current priority; zero never
// R18 - reserved bits read as zero
// R19 - vector read starts service, blocks lower levels
// R20 - fast request when pending and enabled
`timescale 1ns/1ps
module irq_channel_regs
    import irq_channel_pkg::*;
(
    // clock and reset
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    // axi4-lite write address and data
    input  wire logic [irq_channel_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                        awprot,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [irq_channel_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                        wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    // axi4-lite write response
    output logic [1:0]                             bresp,
    output logic                                   bvalid,
    input  wire logic                              bready,
    // axi4-lite read
    input  wire logic [irq_channel_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                        arprot,
    input  wire logic                              arvalid,
    output logic                                   arready,
    output logic [irq_channel_pkg::DATA_W-1:0]     rdata,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready,
    // peripheral request lines
    input  wire logic [irq_channel_pkg::NUM_CH-1:0] channel_request,
    input  wire logic [irq_channel_pkg::NUM_FAST-1:0] fast_request,
    // rest of the controller
    input  wire logic                              normal_irq_enable,
    input  wire logic                              controller_soft_reset,
    input  wire logic [irq_channel_pkg::VEC_W-1:0] vector_base_high,
    // processor side
    output logic                                   processor_irq_line,
    output logic                                   fast_irq_request,
    output logic [irq_channel_pkg::PRIO_W-1:0]     current_service_priority,
    output logic [irq_channel_pkg::CHAN_W-1:0]     current_channel
);

    // ==========================================================
    // state
    logic [NUM_FAST-1:0]              fast_channel_enable;
    logic [NUM_FAST-1:0]              fast_channel_pending;
    logic [NUM_CH-1:0]                channel_enable_bits;
    logic [NUM_CH-1:0]                channel_pending_bits;
    logic [VEC_W-1:0]                 source_vector_part [NUM_CH];
    logic [PRIO_W-1:0]                source_priority_level [NUM_CH];
    logic [PRIO_W+CHAN_W-1:0]         prio_stack [STACK_DEPTH];
    logic [SP_W-1:0]                  stack_ptr;
    logic [CHAN_W-1:0]                irq_channel;

    logic [ADDR_W-1:0]                aw_addr;
    logic                             aw_full;
    logic [DATA_W-1:0]                w_data;
    logic [3:0]                       w_strb;
    logic                             w_full;

    // ==========================================================
    // write channel
    logic                             wr_fire;
    logic [DATA_W-1:0]                byte_mask;
    logic [DATA_W-1:0]                wr_ones;
    logic                             wr_is_source;
    logic [CHAN_W-1:0]                wr_index;
    logic [ADDR_W-1:0]                wr_rel;
    logic                             wr_mapped;

    assign wr_fire = aw_full && w_full && !bvalid;
    assign byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_ones = w_data & byte_mask;
    assign wr_rel = aw_addr - SOURCE_FIRST_OFS;
    assign wr_index = wr_rel[CHAN_W+1:2];
    assign wr_is_source = (aw_addr >= SOURCE_FIRST_OFS) && (aw_addr <= SOURCE_LAST_OFS)
                          && (aw_addr[1:0] == 2'h0);
    assign wr_mapped = wr_is_source || aw_addr == VECTOR_READOUT_OFS
                       || aw_addr == FAST_CHANNEL_CONTROL_OFS
                       || aw_addr == CHANNEL_ENABLE_OFS || aw_addr == CHANNEL_PENDING_OFS;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            awready <= 1'b0;
            aw_addr <= '0;
        end
        else if (awvalid && awready)
        begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr;
        end
        else if (wr_fire)
        begin
            aw_full <= 1'b0;
            awready <= 1'b1;
        end
        else
            awready <= !aw_full;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full <= 1'b0;
            wready <= 1'b0;
            w_data <= '0;
            w_strb <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            w_full <= 1'b1;
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
        end
        else if (wr_fire)
        begin
            w_full <= 1'b0;
            wready <= 1'b1;
        end
        else
            wready <= !w_full;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // ==========================================================
    // fast channels
    logic [NUM_FAST-1:0]              fast_clear;
    assign fast_clear = (wr_fire && aw_addr == FAST_CHANNEL_CONTROL_OFS)
                        ? wr_ones[FAST_PENDING_LSB +: NUM_FAST] : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fast_channel_enable <= '0;
        else if (wr_fire && aw_addr == FAST_CHANNEL_CONTROL_OFS && w_strb[0])
            fast_channel_enable <= w_data[FAST_ENABLE_LSB +: NUM_FAST];
    end

    // request sets win over a same-cycle clear; only software clears [R2] [R3]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fast_channel_pending <= '0;
        else
            fast_channel_pending <= (fast_channel_pending & ~fast_clear) | fast_request;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fast_irq_request <= 1'b0;
        else
            fast_irq_request <= |(fast_channel_pending & fast_channel_enable); // [R1] [R20]
    end

    // ==========================================================
    // normal channels
    logic [NUM_CH-1:0]                pend_clear;
    assign pend_clear = (wr_fire && aw_addr == CHANNEL_PENDING_OFS) ? wr_ones : '0; // [R7]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            channel_enable_bits <= REG_RESET;
        else if (wr_fire && aw_addr == CHANNEL_ENABLE_OFS)
            channel_enable_bits <= (channel_enable_bits & ~byte_mask) | wr_ones; // [R4]
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_chan
            // set wins over clear so a request in the clearing cycle is kept
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    channel_pending_bits[gi] <= 1'b0;
                else if (channel_enable_bits[gi] && channel_request[gi]) // [R5] [R6]
                    channel_pending_bits[gi] <= 1'b1;
                else if (pend_clear[gi])
                    channel_pending_bits[gi] <= 1'b0;
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    source_vector_part[gi] <= VECTOR_RESET;
                    source_priority_level[gi] <= PRIO_RESET; // [R16]
                end
                else if (wr_fire && wr_is_source && wr_index == CHAN_W'(gi)) // [R14]
                begin
                    if (w_strb[2])
                        source_vector_part[gi][7:0] <= w_data[SOURCE_VECTOR_LSB +: 8];
                    if (w_strb[3])
                        source_vector_part[gi][15:8] <= w_data[SOURCE_VECTOR_LSB+8 +: 8];
                    if (w_strb[0])
                        source_priority_level[gi] <= w_data[SOURCE_PRIO_LSB +: PRIO_W];
                end
            end
        end
    endgenerate

    // ==========================================================
    // arbitration: highest level above the current one, lowest channel on a tie
    logic                             best_found;
    logic [CHAN_W-1:0]                best_chan;
    logic [PRIO_W-1:0]                best_prio;

    always_comb
    begin
        best_found = 1'b0;
        best_chan = '0;
        best_prio = current_service_priority;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // a level-zero channel can never exceed the current level [R17] [R19]
            if (channel_pending_bits[i] && channel_enable_bits[i]
                && source_priority_level[i] > best_prio)
            begin
                best_found = 1'b1;
                best_chan = CHAN_W'(i);
                best_prio = source_priority_level[i];
            end
        end
    end

    // ==========================================================
    // read channel
    logic                             rd_fire;
    logic                             vector_read;
    logic [DATA_W-1:0]                rd_mux;
    logic                             rd_mapped;
    logic [ADDR_W-1:0]                rd_rel;
    logic [CHAN_W-1:0]                rd_index;

    assign rd_fire = arvalid && arready;
    assign vector_read = rd_fire && araddr == VECTOR_READOUT_OFS;
    assign rd_rel = araddr - SOURCE_FIRST_OFS;
    assign rd_index = rd_rel[CHAN_W+1:2];

    always_comb
    begin
        rd_mux = REG_RESET;
        rd_mapped = 1'b1;
        if (araddr == VECTOR_READOUT_OFS)
            rd_mux = {vector_base_high, source_vector_part[irq_channel]}; // [R15]
        else if (araddr == FAST_CHANNEL_CONTROL_OFS)
            rd_mux[3:0] = {fast_channel_pending, fast_channel_enable}; // [R18]
        else if (araddr == CHANNEL_ENABLE_OFS)
            rd_mux = channel_enable_bits;
        else if (araddr == CHANNEL_PENDING_OFS)
            rd_mux = channel_pending_bits;
        else if (araddr >= SOURCE_FIRST_OFS && araddr <= SOURCE_LAST_OFS
                 && araddr[1:0] == 2'h0)
        begin
            rd_mux[31:16] = source_vector_part[rd_index];
            rd_mux[3:0] = source_priority_level[rd_index]; // [R18]
        end
        else
            rd_mapped = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= REG_RESET;
            rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
        else
            arready <= !rvalid;
    end

    // ==========================================================
    // processor request line and priority stack
    logic                             in_service;
    logic                             eoi;
    logic                             do_push;
    logic                             do_pop;

    assign in_service = stack_ptr != '0;
    // clearing the serviced bit ends service at once, even mid-routine [R8] [R10] [R11]
    assign eoi = in_service && pend_clear[current_channel];
    // with the global enable low the stack is frozen and the pop is simply lost [R13] [R12]
    assign do_pop = eoi && normal_irq_enable;
    assign do_push = vector_read && processor_irq_line && normal_irq_enable
                     && stack_ptr < SP_W'(STACK_DEPTH);

    // only a vector read or a controller reset drops the line [R9]
    always_ff @(posedge aclk)
    begin
        if (!aresetn || controller_soft_reset)
        begin
            processor_irq_line <= 1'b0;
            irq_channel <= '0;
        end
        else if (processor_irq_line)
        begin
            if (vector_read)
                processor_irq_line <= 1'b0; // [R19]
        end
        else if (normal_irq_enable && best_found)
        begin
            processor_irq_line <= 1'b1;
            irq_channel <= best_chan;
        end
    end

    // a pop in the same cycle as a push is lost: the push branch takes precedence
    always_ff @(posedge aclk)
    begin
        if (!aresetn || controller_soft_reset)
        begin
            stack_ptr <= '0;
            current_service_priority <= PRIO_RESET;
            current_channel <= '0;
        end
        else if (do_push)
        begin
            prio_stack[stack_ptr[3:0]] <= {current_service_priority, current_channel};
            stack_ptr <= stack_ptr + SP_W'(1);
            current_service_priority <= source_priority_level[irq_channel]; // [R19]
            current_channel <= irq_channel;
        end
        else if (do_pop)
        begin
            stack_ptr <= stack_ptr - SP_W'(1); // [R8]
            {current_service_priority, current_channel} <= prio_stack[stack_ptr[3:0] - 4'h1];
        end
    end

endmodule

/* File: irq_regs_properties.sv */
// port assertions for the channel register block
`timescale 1ns/1ps
module irq_regs_properties
    import irq_channel_pkg::*;
(
    // clock and reset
    input wire logic                                aclk,
    input wire logic                                aresetn,
    // register bus
    input wire logic                                awvalid,
    input wire logic                                awready,
    input wire logic [1:0]                          bresp,
    input wire logic                                bvalid,
    input wire logic                                bready,
    input wire logic [irq_channel_pkg::ADDR_W-1:0]  araddr,
    input wire logic                                arvalid,
    input wire logic                                arready,
    input wire logic [irq_channel_pkg::DATA_W-1:0]  rdata,
    input wire logic                                rvalid,
    input wire logic                                rready,
    // controller side
    input wire logic                                normal_irq_enable,
    input wire logic                                controller_soft_reset,
    input wire logic                                processor_irq_line,
    input wire logic [irq_channel_pkg::PRIO_W-1:0]  current_service_priority,
    input wire logic [irq_channel_pkg::CHAN_W-1:0]  current_channel
);
    // ==========================================================
    // helpers
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic vec_rd;
    assign vec_rd = arvalid && arready && (araddr == VECTOR_READOUT_OFS);

    // ==========================================================
    // interrupt line and service priority
    irq_hold_a: assert property (processor_irq_line && !vec_rd && !controller_soft_reset
        |=> processor_irq_line) else $error("irq line fell without vector read");
    irq_release_a: assert property (processor_irq_line && vec_rd
        |=> !processor_irq_line) else $error("irq line held after vector read");
    soft_clear_a: assert property (controller_soft_reset |=> !processor_irq_line
        && current_service_priority == PRIO_RESET && current_channel == 5'h00)
        else $error("soft reset left service state");
    irq_gate_a: assert property ($rose(processor_irq_line) |-> $past(normal_irq_enable))
        else $error("irq raised with global enable low");
    stack_freeze_a: assert property (!normal_irq_enable && !controller_soft_reset
        |=> $stable(current_service_priority)) else $error("priority moved while frozen");
    serve_level_a: assert property (vec_rd && processor_irq_line && normal_irq_enable
        && !controller_soft_reset |=> current_service_priority != 4'h0)
        else $error("service entered at level zero");

    // ==========================================================
    // register bus answers
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
endmodule

bind irq_channel_regs irq_regs_properties chk_i (.*);

/* File: periph_sources.sv */
// peripheral request sources
`timescale 1ns/1ps
module periph_sources
    import irq_channel_pkg::*;
(
    // clock
    input wire logic                                aclk,
    // request lines
    output logic [irq_channel_pkg::NUM_CH-1:0]      channel_request,
    output logic [irq_channel_pkg::NUM_FAST-1:0]    fast_request
);
    // ==========================================================
    // level requests, held for len cycles and then dropped whether served or not
    initial
    begin
        channel_request = '0;
        fast_request = '0;
    end
    task automatic raise(input int ch, input bit fast, input int len);
        @(posedge aclk);
        if (fast) fast_request[ch] <= 1'b1;
        else channel_request[ch] <= 1'b1;
        repeat (len) @(posedge aclk);
        fast_request <= '0;
        channel_request <= '0;
    endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the channel register block
`timescale 1ns/1ps
module tb_top;
    import irq_channel_pkg::*;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, fast_irq_request;
    logic              normal_irq_enable, controller_soft_reset, processor_irq_line;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, exp_en, exp_pend, exp_fast;
    logic [DATA_W-1:0] exp_src [NUM_CH];
    logic [1:0]        bresp, rresp;
    logic [NUM_CH-1:0] channel_request;
    logic [1:0]        fast_request;
    logic [2:0]        awprot, arprot;
    logic [3:0]        wstrb;
    logic [VEC_W-1:0]  vector_base_high;
    logic [3:0]        current_service_priority;
    logic [4:0]        current_channel;
    int                errors, total_checks, stk_prio[$], stk_ch[$];

    // ==========================================================
    // design and far side
    irq_channel_regs dut (.*);
    periph_sources src (.*);

    // ==========================================================
    // model and checking
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic bit is_src(input logic [7:0] a);
        return a >= SOURCE_FIRST_OFS && a <= SOURCE_LAST_OFS && a[1:0] == 2'h0;
    endfunction
    function automatic bit mapped(input logic [7:0] a);
        return is_src(a) || a == 8'h18 || a == 8'h1c || a == 8'h20 || a == 8'h40;
    endfunction
    function automatic logic [31:0] mdl(input logic [7:0] a);
        if (a == FAST_CHANNEL_CONTROL_OFS) return exp_fast;
        if (a == CHANNEL_ENABLE_OFS) return exp_en;
        if (a == CHANNEL_PENDING_OFS) return exp_pend;
        if (a == VECTOR_READOUT_OFS) return {vector_base_high, exp_src[stk_ch[$]][31:16]};
        return exp_src[(a - SOURCE_FIRST_OFS) >> 2];
    endfunction
    function automatic logic [31:0] cur_prio();
        return (stk_prio.size() > 0) ? 32'(stk_prio[$]) : 32'h0;
    endfunction
    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // ==========================================================
    // register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (n < 50)
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        bready <= 1'b0;
        if (n >= 50) errors++;
        chk({30'h0, bresp}, {30'h0, mapped(a) ? RESP_OKAY : RESP_SLVERR});
        if (a == FAST_CHANNEL_CONTROL_OFS) exp_fast = {28'h0, exp_fast[3:2] & ~d[3:2], d[1:0]};
        if (a == CHANNEL_ENABLE_OFS) exp_en = d;
        if (a == CHANNEL_PENDING_OFS && normal_irq_enable && stk_ch.size() > 0 && d[stk_ch[$]])
        begin
            void'(stk_ch.pop_back());
            void'(stk_prio.pop_back());
        end
        if (a == CHANNEL_PENDING_OFS) exp_pend = exp_pend & ~d;
        if (is_src(a)) exp_src[(a - SOURCE_FIRST_OFS) >> 2] = d & 32'hffff000f;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (n < 50)
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        rready <= 1'b0;
        if (n >= 50) errors++;
        if (mapped(a)) chk(rdata, mdl(a));
        chk({30'h0, rresp}, {30'h0, mapped(a) ? RESP_OKAY : RESP_SLVERR});
    endtask
    task automatic pulse(input int ch, input bit fast);
        src.raise(ch, fast, 2);
        if (fast) exp_fast[2 + ch] = 1'b1;
        else if (exp_en[ch]) exp_pend[ch] = 1'b1;
        idle(3);
    endtask
    task automatic wait_line();
        int n;
        n = 0;
        while (processor_irq_line !== 1'b1 && n < 20)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog, tests
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial
    begin
        #100000;
        errors++;
        close_out();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {normal_irq_enable, controller_soft_reset, awaddr, araddr, wdata, awprot, arprot} = '0;
        wstrb = 4'hf;
        {vector_base_high, exp_en, exp_pend, exp_fast, errors, total_checks} = '0;
        foreach (exp_src[i]) exp_src[i] = REG_RESET;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        void'($urandom(50));
        vector_base_high <= 16'($urandom());
        idle(2);
        for (int i = 0; i < NUM_CH; i++) rd(SOURCE_FIRST_OFS + 8'(4 * i));
        rd(FAST_CHANNEL_CONTROL_OFS);
        rd(CHANNEL_PENDING_OFS);
        rd(8'h04);
        wr(8'h10, 32'hffffffff);
        wr(VECTOR_READOUT_OFS, 32'hffffffff);
        for (int i = 0; i < NUM_CH; i++)
        begin
            wr(SOURCE_FIRST_OFS + 8'(4 * i), $urandom());
            rd(SOURCE_FIRST_OFS + 8'(4 * i));
        end
        wr(CHANNEL_ENABLE_OFS, $urandom());
        rd(CHANNEL_ENABLE_OFS);
        wr(CHANNEL_ENABLE_OFS, 32'h0);
        pulse(3, 0);
        rd(CHANNEL_PENDING_OFS);
        wr(CHANNEL_ENABLE_OFS, 32'h00000078);
        pulse(3, 0);
        rd(CHANNEL_PENDING_OFS);
        wr(CHANNEL_PENDING_OFS, 32'h0);
        rd(CHANNEL_PENDING_OFS);
        wr(CHANNEL_PENDING_OFS, 32'h8);
        rd(CHANNEL_PENDING_OFS);
        pulse(1, 1);
        chk({31'h0, fast_irq_request}, 32'h0);
        rd(FAST_CHANNEL_CONTROL_OFS);
        wr(FAST_CHANNEL_CONTROL_OFS, 32'h2);
        idle(2);
        chk({31'h0, fast_irq_request}, 32'h1);
        rd(FAST_CHANNEL_CONTROL_OFS);
        wr(FAST_CHANNEL_CONTROL_OFS, 32'hb);
        rd(FAST_CHANNEL_CONTROL_OFS);
        wr(8'h70, ($urandom() & 32'hffff0000) | 32'h7);
        wr(8'h74, ($urandom() & 32'hffff0000) | 32'h3);
        wr(8'h78, $urandom() & 32'hffff0000);
        normal_irq_enable <= 1'b1;
        pulse(6, 0);
        chk({31'h0, processor_irq_line}, 32'h0);
        wr(CHANNEL_PENDING_OFS, 32'h40);
        pulse(4, 0);
        wait_line();
        wr(CHANNEL_PENDING_OFS, 32'h10);
        idle(3);
        chk({31'h0, processor_irq_line}, 32'h1);
        stk_prio.push_back(7);
        stk_ch.push_back(4);
        rd(VECTOR_READOUT_OFS);
        idle(1);
        chk({31'h0, processor_irq_line}, 32'h0);
        chk({28'h0, current_service_priority}, cur_prio());
        chk({27'h0, current_channel}, 32'h4);
        pulse(5, 0);
        chk({31'h0, processor_irq_line}, 32'h0);
        pulse(4, 0);
        wr(CHANNEL_PENDING_OFS, 32'h10);
        wait_line();
        chk({31'h0, processor_irq_line}, 32'h1);
        chk({28'h0, current_service_priority}, cur_prio());
        stk_prio.push_back(3);
        stk_ch.push_back(5);
        rd(VECTOR_READOUT_OFS);
        normal_irq_enable <= 1'b0;
        wr(CHANNEL_PENDING_OFS, 32'h20);
        idle(2);
        chk({28'h0, current_service_priority}, cur_prio());
        normal_irq_enable <= 1'b1;
        idle(3);
        chk({28'h0, current_service_priority}, 32'h3);
        pulse(4, 0);
        wait_line();
        controller_soft_reset <= 1'b1;
        @(posedge aclk);
        controller_soft_reset <= 1'b0;
        #1;
        chk({31'h0, processor_irq_line}, 32'h0);
        chk({28'h0, current_service_priority}, 32'h0);
        close_out();
    end
endmodule
